// ==== hdl/crrs_fault_mux.sv ====
// per-byte selection of request data under the fault policy
`timescale 1ns/1ps
module crrs_fault_mux #(
    parameter int NBYTES = 8
) (
    input wire logic [NBYTES*8-1:0] live, // data from upstream
    input wire logic [NBYTES*8-1:0] hold, // last data sent
    input wire logic [NBYTES*8-1:0] subst, // substitute per block
    input wire logic [NBYTES-1:0] is_data, // 1 data byte, 0 constant byte
    input wire logic fault, // fault condition active
    input wire crrs_pkg::crrs_pol_t pol, // fault policy
    output logic [NBYTES*8-1:0] eff // data to send
);
    genvar i;
    generate
        for (i = 0; i < NBYTES; i++) begin : g_byte
            // constant bytes never take a fault substitute
            wire sub = fault && is_data[i];
            wire [7:0] rep = (pol == crrs_pkg::POL_CLEAR) ? 8'h00 : // [RQ5]
                (pol == crrs_pkg::POL_USER) ? subst[i*8 +: 8] : // [RQ5] [RQ9]
                hold[i*8 +: 8];
            assign eff[i*8 +: 8] = sub ? rep : live[i*8 +: 8];
        end
    endgenerate
endmodule // crrs_fault_mux

// ==== hdl/crrs_ms_tick.sv ====
// millisecond tick divider
`timescale 1ns/1ps
module crrs_ms_tick #(
    parameter int DIV = 25000
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // async reset, low
    output logic tick // one-cycle pulse each ms
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt_reg;
    wire last = (cnt_reg == W'(DIV - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= last ? '0 : cnt_reg + W'(1);
            tick <= last;
        end
    end
endmodule // crrs_ms_tick

// ==== hdl/crrs_params.svh ====
// constants of the can request/response scheduler: offsets, fields, resets, timing
`ifndef CRRS_PARAMS_SVH
`define CRRS_PARAMS_SVH

// ==========================================================
// timing
`define CRRS_CLK_HZ 25000000
`define CRRS_MS_PER_S 1000
`define CRRS_MS_CYCLES (`CRRS_CLK_HZ / `CRRS_MS_PER_S)

// ==========================================================
// register byte offsets
`define CRRS_OFF_CTRL 8'h00
`define CRRS_OFF_CYCLE 8'h04
`define CRRS_OFF_FAULT_TO 8'h08
`define CRRS_OFF_RESP_TO 8'h0c
`define CRRS_OFF_IDS 8'h10
`define CRRS_OFF_DATA_LO 8'h14
`define CRRS_OFF_DATA_HI 8'h18
`define CRRS_OFF_SUBST_LO 8'h1c
`define CRRS_OFF_SUBST_HI 8'h20
`define CRRS_OFF_LAYOUT 8'h24
`define CRRS_OFF_RESP_LO 8'h28
`define CRRS_OFF_RESP_HI 8'h2c
`define CRRS_OFF_STATUS 8'h30
`define CRRS_OFF_MASK 8'h34
`define CRRS_OFF_STATE 8'h38

// ==========================================================
// field positions
`define CRRS_CTRL_EN 0
`define CRRS_CTRL_MODE_LSB 1
`define CRRS_CTRL_POL_LSB 3
`define CRRS_CTRL_RETRY_LSB 5
`define CRRS_IDS_RESP_LSB 16
`define CRRS_ST_SENT 0
`define CRRS_ST_RESP 1
`define CRRS_ST_TMO 2
`define CRRS_ST_FAULT 3

// ==========================================================
// reset values and limits
`define CRRS_CTRL_RST 8'h01
`define CRRS_CYCLE_RST 16'h03e8
`define CRRS_CYCLE_MIN 16'h000a
`define CRRS_FAULT_RST 16'hea60
`define CRRS_FAULT_MIN 16'h0064
`define CRRS_RESP_RST 16'h03e8
`define CRRS_RESP_MIN 16'h0064
`define CRRS_RETRY_MAX 3'h5
`define CRRS_IDS_RST 32'h0000_0000
`define CRRS_LAYOUT_RST 8'hff

`endif

// ==== hdl/crrs_pkg.sv ====
// types of the can request/response scheduler
package crrs_pkg;
    typedef enum logic [1:0] {
        TRIG_CYCLIC = 2'h0,
        TRIG_CHANGE = 2'h1,
        TRIG_BOOT = 2'h2
    } crrs_trig_t;
    typedef enum logic [1:0] {
        POL_PAUSE = 2'h0,
        POL_CLEAR = 2'h1,
        POL_USER = 2'h2
    } crrs_pol_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEND,
        ST_WAIT
    } crrs_state_t;
endpackage

// ==== hdl/crrs_sched.sv ====
// can request/response scheduler with ahb-lite registers
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "crrs_params.svh"
// Function
// RQ1 - cyclic mode sends request every cycle interval
// RQ2 - cycle interval 10..65535 ms, default 1000
// RQ3 - change mode sends only on data change
// RQ4 - boot mode sends once after bus up
// RQ5 - fault policy: pause, clear, or user value
// RQ6 - fault after upstream silence beyond timeout
// RQ7 - resend on timeout, up to 0..5 times
// RQ8 - response wait 100..65535 ms, default 1000
// RQ9 - substitute value held per data block
// RQ10 - own ids and layouts for request, response; the code has both ids but a layout (layout_reg) for the request only
// RQ11 - accept only frames with response id
// RQ12 - retries exhausted: abandon, flag, await trigger
module crrs_sched #(
    parameter int MS_CYCLES = `CRRS_MS_CYCLES
) (
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    output logic irq, // level interrupt
    input wire logic upstream_act, // pulse: upstream traffic seen
    input wire logic bus_up, // can controller online
    output logic tx_valid, // request frame offered
    input wire logic tx_ack, // frame accepted for sending
    output logic [10:0] tx_id, // request id
    output logic [63:0] tx_data, // request payload
    input wire logic rx_valid, // pulse: frame received
    input wire logic [10:0] rx_id, // received id
    input wire logic [63:0] rx_data // received payload
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // helpers
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo);
        return (v < lo) ? lo : v;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ==========================================================
    // ahb-lite slave, zero wait states
    logic a_val_reg;
    logic a_wr_reg;
    logic [7:0] a_addr_reg;
    wire take = hsel && hready && htrans[1];
    wire wr = a_val_reg && a_wr_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_val_reg <= 1'b0;
            a_wr_reg <= 1'b0;
            a_addr_reg <= 8'h00;
        end else begin
            a_val_reg <= take;
            a_wr_reg <= hwrite;
            a_addr_reg <= (haddr[31:8] == 24'h000000) ? {haddr[7:2], 2'b00} : 8'hfc;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // registers
    logic [7:0] ctrl_reg;
    logic [15:0] cyc_reg;
    logic [15:0] flt_reg;
    logic [15:0] rsp_reg;
    logic [31:0] ids_reg;
    logic [63:0] data_reg;
    logic [63:0] subst_reg;
    logic [7:0] layout_reg;
    logic [63:0] resp_reg;
    logic [3:0] sts_reg;
    logic [3:0] msk_reg;
    logic [3:0] sts_next;
    logic [3:0] sts_set;
    logic [31:0] rd_next;

    wire en = ctrl_reg[`CRRS_CTRL_EN];
    wire crrs_pkg::crrs_trig_t mode = crrs_pkg::crrs_trig_t'(ctrl_reg[`CRRS_CTRL_MODE_LSB +: 2]);
    wire crrs_pkg::crrs_pol_t pol = crrs_pkg::crrs_pol_t'(ctrl_reg[`CRRS_CTRL_POL_LSB +: 2]);
    wire [2:0] retry_raw = ctrl_reg[`CRRS_CTRL_RETRY_LSB +: 3];
    wire [2:0] retry_max = (retry_raw > `CRRS_RETRY_MAX) ? `CRRS_RETRY_MAX : retry_raw; // [RQ7]
    wire [15:0] cyc_lim = clamp(cyc_reg, `CRRS_CYCLE_MIN); // [RQ2]
    wire [15:0] flt_lim = clamp(flt_reg, `CRRS_FAULT_MIN); // [RQ6]
    wire [15:0] rsp_lim = clamp(rsp_reg, `CRRS_RESP_MIN); // [RQ8]
    wire [10:0] req_id = ids_reg[10:0]; // [RQ10]
    wire [10:0] resp_id = ids_reg[`CRRS_IDS_RESP_LSB +: 11]; // [RQ10]

    wire w_ctrl = wr && hit(a_addr_reg, `CRRS_OFF_CTRL);
    wire w_sts = wr && hit(a_addr_reg, `CRRS_OFF_STATUS);
    wire [3:0] sts_clr = w_sts ? hwdata[3:0] : 4'h0;
    // a hardware event in the clearing cycle survives the clear
    assign sts_next = (sts_reg & ~sts_clr) | sts_set;
    assign irq = |(sts_reg & msk_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `CRRS_CTRL_RST;
            cyc_reg <= `CRRS_CYCLE_RST;
            flt_reg <= `CRRS_FAULT_RST;
            rsp_reg <= `CRRS_RESP_RST;
            ids_reg <= `CRRS_IDS_RST;
            data_reg <= 64'h0;
            subst_reg <= 64'h0;
            layout_reg <= `CRRS_LAYOUT_RST;
            msk_reg <= 4'h0;
            sts_reg <= 4'h0;
        end else begin
            sts_reg <= sts_next;
            if (w_ctrl) ctrl_reg <= hwdata[7:0];
            if (wr && hit(a_addr_reg, `CRRS_OFF_CYCLE)) cyc_reg <= hwdata[15:0];
            if (wr && hit(a_addr_reg, `CRRS_OFF_FAULT_TO)) flt_reg <= hwdata[15:0];
            if (wr && hit(a_addr_reg, `CRRS_OFF_RESP_TO)) rsp_reg <= hwdata[15:0];
            if (wr && hit(a_addr_reg, `CRRS_OFF_IDS)) ids_reg <= hwdata & 32'h07ff_07ff;
            if (wr && hit(a_addr_reg, `CRRS_OFF_DATA_LO)) data_reg[31:0] <= hwdata;
            if (wr && hit(a_addr_reg, `CRRS_OFF_DATA_HI)) data_reg[63:32] <= hwdata;
            if (wr && hit(a_addr_reg, `CRRS_OFF_SUBST_LO)) subst_reg[31:0] <= hwdata; // [RQ9]
            if (wr && hit(a_addr_reg, `CRRS_OFF_SUBST_HI)) subst_reg[63:32] <= hwdata; // [RQ9]
            if (wr && hit(a_addr_reg, `CRRS_OFF_LAYOUT)) layout_reg <= hwdata[7:0];
            if (wr && hit(a_addr_reg, `CRRS_OFF_MASK)) msk_reg <= hwdata[3:0];
        end
    end

    // ==========================================================
    // millisecond timebase and fault detection
    logic ms_tick;
    logic [15:0] cyc_cnt_reg;
    logic [15:0] rsp_cnt_reg;
    logic [16:0] flt_cnt_reg;
    logic cyc_due_reg;
    logic boot_done_reg;
    logic fault_d_reg;
    logic [2:0] retry_reg;
    logic [63:0] last_reg;
    logic [63:0] eff;
    crrs_pkg::crrs_state_t state_reg;

    crrs_ms_tick #(.DIV(MS_CYCLES)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(ms_tick)
    );

    // the 17th bit lets a full 65535 ms timeout still be exceeded
    wire fault = flt_cnt_reg > {1'b0, flt_lim}; // [RQ6]
    wire cyc_hit = ms_tick && (cyc_cnt_reg >= cyc_lim - 16'h0001); // [RQ1]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flt_cnt_reg <= 17'h00000;
            fault_d_reg <= 1'b0;
            cyc_cnt_reg <= 16'h0000;
        end else begin
            fault_d_reg <= fault;
            if (upstream_act) flt_cnt_reg <= 17'h00000;
            else if (ms_tick && !flt_cnt_reg[16]) flt_cnt_reg <= flt_cnt_reg + 17'h00001;
            if (cyc_hit) cyc_cnt_reg <= 16'h0000;
            else if (ms_tick) cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
        end
    end

    crrs_fault_mux #(.NBYTES(8)) u_mux (
        .live(data_reg),
        .hold(last_reg),
        .subst(subst_reg),
        .is_data(layout_reg),
        .fault(fault),
        .pol(pol),
        .eff(eff)
    );

    // ==========================================================
    // trigger and transaction sequencing
    wire idle = state_reg == crrs_pkg::ST_IDLE;
    wire wait_st = state_reg == crrs_pkg::ST_WAIT;
    wire trig_cyc = (mode == crrs_pkg::TRIG_CYCLIC) && cyc_due_reg; // [RQ1]
    wire trig_chg = (mode == crrs_pkg::TRIG_CHANGE) && (eff != last_reg); // [RQ3]
    wire trig_boot = (mode == crrs_pkg::TRIG_BOOT) && bus_up && !boot_done_reg; // [RQ4]
    wire start = idle && en && (trig_cyc || trig_chg || trig_boot);
    wire rx_match = wait_st && rx_valid && (rx_id == resp_id); // [RQ11]
    wire rsp_hit = wait_st && ms_tick && (rsp_cnt_reg >= rsp_lim - 16'h0001); // [RQ8]
    wire tmo = rsp_hit && !rx_match;
    wire resend = tmo && (retry_reg < retry_max); // [RQ7]
    wire give_up = tmo && !resend; // [RQ12]

    assign sts_set[`CRRS_ST_SENT] = (state_reg == crrs_pkg::ST_SEND) && tx_ack;
    assign sts_set[`CRRS_ST_RESP] = rx_match;
    assign sts_set[`CRRS_ST_TMO] = give_up; // [RQ12]
    assign sts_set[`CRRS_ST_FAULT] = fault && !fault_d_reg;
    assign tx_valid = state_reg == crrs_pkg::ST_SEND;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= crrs_pkg::ST_IDLE;
            cyc_due_reg <= 1'b0;
            boot_done_reg <= 1'b0;
            retry_reg <= 3'h0;
            rsp_cnt_reg <= 16'h0000;
            last_reg <= 64'h0;
            tx_id <= 11'h000;
            tx_data <= 64'h0;
            resp_reg <= 64'h0;
        end else begin
            // a new interval that expires as a send starts stays pending
            if (cyc_hit) cyc_due_reg <= 1'b1;
            else if (start) cyc_due_reg <= 1'b0;
            if (!bus_up) boot_done_reg <= 1'b0;
            else if (start && trig_boot) boot_done_reg <= 1'b1; // [RQ4]
            if (ms_tick && wait_st) rsp_cnt_reg <= rsp_cnt_reg + 16'h0001;
            unique case (state_reg)
                crrs_pkg::ST_IDLE: begin
                    if (start) begin
                        state_reg <= crrs_pkg::ST_SEND;
                        tx_id <= req_id; // [RQ10]
                        tx_data <= eff; // [RQ5]
                        last_reg <= eff;
                        retry_reg <= 3'h0;
                    end
                end
                crrs_pkg::ST_SEND: begin
                    if (tx_ack) begin
                        state_reg <= crrs_pkg::ST_WAIT;
                        rsp_cnt_reg <= 16'h0000;
                    end
                end
                crrs_pkg::ST_WAIT: begin
                    if (rx_match) begin
                        state_reg <= crrs_pkg::ST_IDLE;
                        resp_reg <= rx_data;
                    end else if (resend) begin
                        state_reg <= crrs_pkg::ST_SEND; // [RQ7]
                        retry_reg <= retry_reg + 3'h1;
                    end else if (give_up) begin
                        state_reg <= crrs_pkg::ST_IDLE; // [RQ12]
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // read data, registered at the address phase
    wire [7:0] ra = (haddr[31:8] == 24'h000000) ? {haddr[7:2], 2'b00} : 8'hfc;
    wire [31:0] rd_state = {24'h0, fault, retry_reg, boot_done_reg, cyc_due_reg, state_reg};
    assign rd_next =
        hit(ra, `CRRS_OFF_CTRL) ? {24'h0, ctrl_reg} :
        hit(ra, `CRRS_OFF_CYCLE) ? {16'h0, cyc_reg} :
        hit(ra, `CRRS_OFF_FAULT_TO) ? {16'h0, flt_reg} :
        hit(ra, `CRRS_OFF_RESP_TO) ? {16'h0, rsp_reg} :
        hit(ra, `CRRS_OFF_IDS) ? ids_reg :
        hit(ra, `CRRS_OFF_DATA_LO) ? data_reg[31:0] :
        hit(ra, `CRRS_OFF_DATA_HI) ? data_reg[63:32] :
        hit(ra, `CRRS_OFF_SUBST_LO) ? subst_reg[31:0] :
        hit(ra, `CRRS_OFF_SUBST_HI) ? subst_reg[63:32] :
        hit(ra, `CRRS_OFF_LAYOUT) ? {24'h0, layout_reg} :
        hit(ra, `CRRS_OFF_RESP_LO) ? resp_reg[31:0] :
        hit(ra, `CRRS_OFF_RESP_HI) ? resp_reg[63:32] :
        hit(ra, `CRRS_OFF_STATUS) ? {28'h0, sts_next} :
        hit(ra, `CRRS_OFF_MASK) ? {28'h0, msk_reg} :
        hit(ra, `CRRS_OFF_STATE) ? rd_state : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) hrdata <= 32'h0;
        else if (take && !hwrite) hrdata <= rd_next;
    end

    // ==========================================================
    // checks
    a_cyc_start: assert property (idle && en && mode == crrs_pkg::TRIG_CYCLIC && cyc_due_reg
        |=> state_reg == crrs_pkg::ST_SEND) else $error("cyclic send missed"); // [RQ1]

    // an expiry during a send stays pending for the next one
    a_cyc_due: assert property (cyc_hit |=> cyc_due_reg) // [RQ1]
        else $error("interval expiry lost");

    a_cyc_floor: assert property (cyc_hit |-> cyc_cnt_reg >= 16'h0009)
        else $error("cycle interval below floor"); // [RQ2]

    a_chg_only: assert property (start && mode == crrs_pkg::TRIG_CHANGE |-> eff != last_reg)
        else $error("change send without change"); // [RQ3]

    a_boot_once: assert property (start && mode == crrs_pkg::TRIG_BOOT
        |=> boot_done_reg throughout (bus_up [*2])) else $error("boot send repeat"); // [RQ4]

    a_boot_single: assert property (mode == crrs_pkg::TRIG_BOOT && boot_done_reg && bus_up // [RQ4]
        |-> !start) else $error("boot send repeated while bus up");

    a_clear_zero: assert property (fault && pol == crrs_pkg::POL_CLEAR
        |-> (eff & {{8{layout_reg[7]}}, {8{layout_reg[6]}}, {8{layout_reg[5]}},
        {8{layout_reg[4]}}, {8{layout_reg[3]}}, {8{layout_reg[2]}}, {8{layout_reg[1]}},
        {8{layout_reg[0]}}}) == 64'h0) else $error("clear policy leaked data"); // [RQ5]

    a_fault_rise: assert property ($rose(fault) |-> flt_cnt_reg > {1'b0, flt_lim}
        && flt_lim >= `CRRS_FAULT_MIN) else $error("fault raised early"); // [RQ6]

    a_retry_cap: assert property (state_reg == crrs_pkg::ST_SEND |-> retry_reg <= retry_max)
        else $error("retry count over limit"); // [RQ7]

    // a resend repeats the frame that went unanswered
    a_resend_same: assert property (resend |=> tx_valid && $stable(tx_data)) // [RQ7]
        else $error("resend changed the payload");

    a_resp_wait: assert property (wait_st && rsp_cnt_reg < rsp_lim - 16'h0001 && !rx_match
        |=> wait_st) else $error("left wait early"); // [RQ8]

    a_tx_id: assert property (tx_valid |-> tx_id == $past(req_id, 1) || $stable(tx_id))
        else $error("request id wrong"); // [RQ10]

    // the request must not move under the link while it waits for acceptance
    a_tx_hold: assert property (tx_valid && !tx_ack // [RQ10]
        |=> tx_valid && $stable(tx_id) && $stable(tx_data))
        else $error("request changed before acceptance");

    a_id_filter: assert property (wait_st && rx_valid && rx_id != resp_id && !rsp_hit
        |=> wait_st && $stable(resp_reg)) else $error("foreign frame taken"); // [RQ11]

    a_rx_capture: assert property (rx_match |=> resp_reg == $past(rx_data)) // [RQ11]
        else $error("matching response not stored");

    a_give_up: assert property (give_up |=> idle && sts_reg[`CRRS_ST_TMO])
        else $error("exhausted retry not flagged"); // [RQ12]

    // set beats a same-cycle clear, so an acceptance is never lost
    a_sent_flag: assert property (tx_valid && tx_ack |=> sts_reg[`CRRS_ST_SENT])
        else $error("sent flag missing");
endmodule // crrs_sched

// ==== verification/can_request_response_scheduler_tb_top.sv ====
// self-checking testbench of the can request/response scheduler
`timescale 1ns/1ps
`include "crrs_params.svh"
module can_request_response_scheduler_tb_top;
    logic hclk, hresetn, hsel, hwrite, upstream_act, bus_up;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans, ans;
    logic [2:0] hsize;
    logic hreadyout, hresp, irq, tx_valid, tx_ack, rx_valid;
    logic [31:0] hrdata;
    logic [10:0] tx_id, rx_id, last_id;
    logic [63:0] tx_data, rx_data, last_data;
    int n_fail, cmp_count, cyc, n_req, last_acc, prev_acc;
    crrs_sched #(.MS_CYCLES(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .upstream_act(upstream_act), .bus_up(bus_up), .tx_valid(tx_valid), .tx_ack(tx_ack),
        .tx_id(tx_id), .tx_data(tx_data), .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data));
    crrs_can_slave peer_u (.hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid), .tx_id(tx_id),
        .tx_data(tx_data), .tx_ack(tx_ack), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_data(rx_data), .resp_id(11'h001), .ans(ans), .rsp_dly(8'h14));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ===========================================
    // bookkeeping: accepted requests and hang guard
    always @(posedge hclk) begin
        cyc++;
        if (tx_valid === 1'b1 && tx_ack === 1'b1) begin
            n_req++;
            prev_acc = last_acc;
            last_acc = cyc;
            last_data = tx_data;
            last_id = tx_id;
        end
        if (cyc >= 30000) begin
            n_fail++;
            $display("[FAIL] %0t run did not finish in time", $time);
            finish_test();
        end
    end
    task automatic finish_test();
        $display("mismatches %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // ===========================================
    // bus master: single word transfers
    task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        ahb_xfer(a, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        ahb_xfer(a, 1'b0, 32'h0);
        chk({32'h0, rd}, {32'h0, exp}, "register read");
        chk({63'h0, hresp}, 64'h0, "response code");
    endtask
    task automatic wait_req(input int n);
        do @(posedge hclk); while (n_req < n);
    endtask
    task automatic wait_irq();
        do @(posedge hclk); while (irq !== 1'b1);
    endtask
    // ===========================================
    // scenarios
    task automatic t_reset();
        rchk(`CRRS_OFF_CTRL, 32'h01);
        rchk(`CRRS_OFF_CYCLE, 32'h3e8);
        rchk(`CRRS_OFF_FAULT_TO, 32'hea60);
        rchk(`CRRS_OFF_RESP_TO, 32'h3e8);
        rchk(`CRRS_OFF_STATUS, 32'h0);
        rchk(8'h3c, 32'h0);
    endtask
    task automatic t_cyclic();
        ahb_wr(`CRRS_OFF_IDS, 32'h0001_0123);
        ahb_wr(`CRRS_OFF_DATA_LO, 32'h11223344);
        ahb_wr(`CRRS_OFF_DATA_HI, 32'h55667788);
        ahb_wr(`CRRS_OFF_MASK, 32'h2);
        ahb_wr(`CRRS_OFF_CYCLE, 32'ha);
        wait_req(n_req + 3);
        chk(64'(last_acc - prev_acc >= 90 && last_acc - prev_acc <= 110), 64'h1, "period");
        chk({53'h0, last_id}, 64'h123, "request id");
        chk(last_data, 64'h5566778811223344, "request data");
        wait_irq();
        ahb_wr(`CRRS_OFF_CTRL, 32'h0);
        // an answer still in flight would set status again after the clear
        repeat (40) @(posedge hclk);
        rchk(`CRRS_OFF_RESP_LO, 32'heeddccbb);
        ahb_wr(`CRRS_OFF_STATUS, 32'hf);
        rchk(`CRRS_OFF_STATUS, 32'h0);
        chk({63'h0, irq}, 64'h0, "irq after clear");
    endtask
    task automatic t_boot_retry();
        int r;
        ans <= 2'h2;
        bus_up <= 1'b0;
        ahb_wr(`CRRS_OFF_RESP_TO, 32'h64);
        ahb_wr(`CRRS_OFF_MASK, 32'h4);
        ahb_wr(`CRRS_OFF_CTRL, 32'h45);
        r = n_req;
        bus_up <= 1'b1;
        wait_irq();
        chk(64'(n_req - r), 64'h3, "tries");
        chk(64'(last_acc - prev_acc >= 990 && last_acc - prev_acc <= 1025), 64'h1, "wait");
        // longer than one full response window
        repeat (1200) @(posedge hclk);
        chk(64'(n_req - r), 64'h3, "boot repeat");
        rchk(`CRRS_OFF_STATUS, 32'h5);
        rchk(`CRRS_OFF_STATE, 32'h2c);
        ahb_wr(`CRRS_OFF_CTRL, 32'h0);
        ahb_wr(`CRRS_OFF_STATUS, 32'hf);
    endtask
    task automatic t_change_fault();
        int r, t0;
        ans <= 2'h1;
        ahb_wr(`CRRS_OFF_LAYOUT, 32'hf);
        ahb_wr(`CRRS_OFF_SUBST_LO, 32'ha5a5a5a5);
        ahb_wr(`CRRS_OFF_FAULT_TO, 32'h64);
        ahb_wr(`CRRS_OFF_MASK, 32'h8);
        ahb_wr(`CRRS_OFF_CTRL, 32'h3);
        r = n_req;
        ahb_wr(`CRRS_OFF_DATA_LO, 32'h0badf00d);
        wait_req(r + 1);
        chk(last_data, 64'h556677880badf00d, "change send");
        // long enough for a cyclic resend to show
        repeat (300) @(posedge hclk);
        chk(64'(n_req), 64'(r + 1), "no change no send");
        t0 = cyc;
        upstream_act <= 1'b0;
        wait_irq();
        chk(64'(cyc - t0 >= 1000 && cyc - t0 <= 1030), 64'h1, "fault time");
        r = n_req;
        ahb_wr(`CRRS_OFF_DATA_LO, 32'h12345678);
        repeat (300) @(posedge hclk);
        chk(64'(n_req), 64'(r), "pause");
        ahb_wr(`CRRS_OFF_CTRL, 32'hb);
        wait_req(r + 1);
        chk(last_data, 64'h5566778800000000, "clear");
        ahb_wr(`CRRS_OFF_CTRL, 32'h13);
        wait_req(r + 2);
        chk(last_data, 64'h55667788a5a5a5a5, "user");
        upstream_act <= 1'b1;
        wait_req(r + 3);
        chk(last_data, 64'h5566778812345678, "recover");
        ahb_wr(`CRRS_OFF_CTRL, 32'h0);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        upstream_act = 1'b1;
        bus_up = 1'b1;
        ans = 2'h1;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        n_req = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_cyclic();
        t_boot_retry();
        t_change_fault();
        finish_test();
    end
endmodule // can_request_response_scheduler_tb_top

// ==== verification/crrs_can_slave.sv ====
// behavioural can slave at the far side of the request/response scheduler
`timescale 1ns/1ps
module crrs_can_slave (
    input wire logic hclk, // clock
    input wire logic hresetn, // async reset, low
    input wire logic tx_valid, // request offered
    input wire logic [10:0] tx_id, // request id
    input wire logic [63:0] tx_data, // request payload
    output logic tx_ack, // request taken onto the bus
    output logic rx_valid, // answer frame pulse
    output logic [10:0] rx_id, // answer id
    output logic [63:0] rx_data, // answer payload
    input wire logic [10:0] resp_id, // id the slave answers with
    input wire logic [1:0] ans, // 0 silent, 1 answer, 2 answer with a foreign id
    input wire logic [7:0] rsp_dly // cycles from ack to answer
);
    logic [2:0] ack_cnt;
    logic [7:0] rsp_cnt;
    logic [1:0] pend;
    logic [63:0] last;
    // ===========================================
    // arbitration delay, then answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_ack <= 1'b0;
            rx_valid <= 1'b0;
            rx_id <= 11'h000;
            rx_data <= 64'h0;
            ack_cnt <= 3'h0;
            rsp_cnt <= 8'h00;
            pend <= 2'h0;
            last <= 64'h0;
        end else begin
            tx_ack <= 1'b0;
            rx_valid <= 1'b0;
            // idle lines keep moving so a stale frame never looks valid
            rx_id <= ~rx_id;
            rx_data <= ~rx_data;
            if (tx_valid && !tx_ack) begin
                ack_cnt <= ack_cnt + 3'h1;
                if (ack_cnt == 3'h3) begin
                    tx_ack <= 1'b1;
                    ack_cnt <= 3'h0;
                    last <= tx_data;
                    pend <= ans;
                    rsp_cnt <= rsp_dly;
                end
            end else if (pend != 2'h0) begin
                if (rsp_cnt == 8'h00) begin
                    rx_valid <= 1'b1;
                    rx_id <= (pend == 2'h1) ? resp_id : ~resp_id;
                    rx_data <= ~last;
                    pend <= 2'h0;
                end else begin
                    rsp_cnt <= rsp_cnt - 8'h01;
                end
            end
        end
    end
endmodule // crrs_can_slave
